//--- hw/rtc_preset_rom.sv
`timescale 1ns/10ps
`default_nettype none
module rtc_preset_rom (
   input wire logic sys_clk,
   input wire logic rstn,
   input wire logic [1:0] kind,
   input wire logic [2:0] sel,
   input wire logic [15:0] user_value,
   output logic [15:0] start_ff
);
   import rtc_pkg::*;

   logic [15:0] nxt_start;

   // undefined table entries start from zero
   always_comb begin
      nxt_start = START_ZERO;
      if (sel == START_USER) begin
         nxt_start = user_value;
      end else begin
         case (kind)
            KIND_CRC16: begin
               case (sel)
                  3'h1: nxt_start = START16_1;
                  3'h2: nxt_start = START16_2;
                  3'h3: nxt_start = START16_3;
                  3'h7: nxt_start = START16_7;
                  default: nxt_start = START_ZERO;
               endcase
            end
            KIND_CRC8: begin
               case (sel)
                  3'h1: nxt_start = START8_1;
                  3'h2: nxt_start = START8_2;
                  3'h3: nxt_start = START8_3;
                  3'h7: nxt_start = START8_7;
                  default: nxt_start = START_ZERO;
               endcase
            end
            KIND_CRC5: begin
               case (sel)
                  3'h1: nxt_start = START5_1;
                  3'h7: nxt_start = START5_7;
                  default: nxt_start = START_ZERO;
               endcase
            end
            default: nxt_start = START_ZERO;
         endcase
      end
   end

   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         start_ff <= START_ZERO;
      end else begin
         start_ff <= nxt_start;
      end
   end
endmodule : rtc_preset_rom
`default_nettype wire

//--- hw/rtc_regs.sv
// Decided for this implementation: the address-and-strobe port.
`timescale 1ns/10ps
`default_nettype none
module rtc_regs (
   input wire logic sys_clk,
   input wire logic rstn,
   input wire rtc_pkg::rtc_bus_t bus,
   output logic [7:0] rdata_ff,
   input wire logic internal_envelope,
   input wire logic external_modulation_input,
   input wire logic carrier_tick,
   output rtc_pkg::rtc_drv_t drv_ff,
   output logic modulation_out_ff,
   output logic [1:0] carrier_level_reduction,
   output logic full_swing,
   output logic [4:0] residual_carrier,
   output logic [3:0] overshoot_timer_one_value,
   output logic [3:0] expected_load_current_trim,
   input wire logic [15:0] user_crc_start,
   input wire logic frame_start,
   input wire logic data_bit_valid,
   input wire logic data_bit,
   input wire logic frame_end,
   output logic crc_bit_ff,
   output logic crc_bit_valid_ff,
   output logic crc_busy
);
   import rtc_pkg::*;

   logic [7:0] drv_mode_ff, nxt_drv_mode;
   logic [7:0] amp_ff, nxt_amp;
   logic [7:0] mod_ctrl_ff, nxt_mod_ctrl;
   logic [7:0] load_ff, nxt_load;
   logic [7:0] crc_setup_ff, nxt_crc_setup;
   logic [7:0] nxt_rdata;

   // ---------------- register file ----------------
   always_comb begin
      nxt_drv_mode = drv_mode_ff;
      nxt_amp = amp_ff;
      nxt_mod_ctrl = mod_ctrl_ff;
      nxt_load = load_ff;
      nxt_crc_setup = crc_setup_ff;
      if (bus.wr) begin
         case (bus.addr)
            ADDR_DRV_MODE: nxt_drv_mode = bus.wdata & MASK_DRV_MODE;
            ADDR_AMPLITUDE: nxt_amp = bus.wdata & MASK_AMPLITUDE;
            ADDR_MOD_CTRL: nxt_mod_ctrl = bus.wdata & MASK_MOD_CTRL;
            ADDR_LOAD_TRIM: nxt_load = bus.wdata & MASK_LOAD_TRIM;
            ADDR_CRC_SETUP: nxt_crc_setup = bus.wdata & MASK_CRC_SETUP;
            default: ;
         endcase
      end
      nxt_rdata = 8'h00;
      if (bus.rd) begin
         case (bus.addr)
            ADDR_DRV_MODE: nxt_rdata = drv_mode_ff;
            ADDR_AMPLITUDE: nxt_rdata = amp_ff;
            ADDR_MOD_CTRL: nxt_rdata = mod_ctrl_ff;
            ADDR_LOAD_TRIM: nxt_rdata = load_ff;
            ADDR_CRC_SETUP: nxt_rdata = crc_setup_ff;
            default: nxt_rdata = 8'h00;
         endcase
      end
   end

   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         drv_mode_ff <= RST_DRV_MODE;
         amp_ff <= RST_AMPLITUDE;
         mod_ctrl_ff <= RST_MOD_CTRL;
         load_ff <= RST_LOAD_TRIM;
         crc_setup_ff <= RST_CRC_SETUP;
         rdata_ff <= 8'h00;
      end else begin
         drv_mode_ff <= nxt_drv_mode;
         amp_ff <= nxt_amp;
         mod_ctrl_ff <= nxt_mod_ctrl;
         load_ff <= nxt_load;
         crc_setup_ff <= nxt_crc_setup;
         rdata_ff <= nxt_rdata;
      end
   end

   // ---------------- field decode ----------------
   logic drv_on, flip_one, flip_two, mod_flip;
   logic [1:0] mod_source;
   logic [3:0] pulse_len;
   logic [1:0] crc_kind;
   logic [2:0] crc_start_sel;

   assign drv_on = drv_mode_ff[DRV_ON_BIT];
   assign flip_one = drv_mode_ff[DRV_ONE_FLIP_BIT];
   assign flip_two = drv_mode_ff[DRV_TWO_FLIP_BIT];
   assign full_swing = mod_ctrl_ff[MOD_FULL_SWING_BIT];
   assign mod_flip = mod_ctrl_ff[MOD_FLIP_BIT];
   assign mod_source = mod_ctrl_ff[MOD_SOURCE_LSB +: 2];
   assign pulse_len = mod_ctrl_ff[MOD_PULSE_LSB +: 4];
   // the analog stage maps code 0..3 onto supply minus 100/250/500/1000 mV
   assign carrier_level_reduction = full_swing ? 2'h0 : amp_ff[AMP_REDUCTION_LSB +: 2];
   assign residual_carrier = amp_ff[AMP_RESIDUAL_LSB +: 5];
   assign overshoot_timer_one_value = load_ff[LOAD_TIMER_ONE_LSB +: 4];
   assign expected_load_current_trim = load_ff[LOAD_TRIM_LSB +: 4];
   assign crc_kind = crc_setup_ff[CRC_KIND_LSB +: 2];
   assign crc_start_sel = crc_setup_ff[CRC_START_LSB +: 3];

   // ---------------- modulation path ----------------
   logic mod_src, mod_base_ff, nxt_mod_base, nxt_mod_out;
   logic [3:0] pulse_cnt_ff, nxt_pulse_cnt;
   rtc_drv_t nxt_drv;

   always_comb begin
      case (mod_source)
         SRC_ENVELOPE: mod_src = internal_envelope;
         SRC_EXTERNAL: mod_src = external_modulation_input;
         default: mod_src = 1'b0;
      endcase
      nxt_mod_base = mod_src ^ mod_flip;
      // extra pulse starts as the modulation falls back, counted in carrier ticks
      nxt_pulse_cnt = pulse_cnt_ff;
      if (mod_base_ff && !nxt_mod_base) begin
         nxt_pulse_cnt = pulse_len;
      end else if (carrier_tick && pulse_cnt_ff != 4'h0) begin
         nxt_pulse_cnt = pulse_cnt_ff - 4'h1;
      end
      nxt_mod_out = mod_base_ff | (pulse_cnt_ff != 4'h0);
      nxt_drv.one = drv_on & (modulation_out_ff ^ flip_one);
      nxt_drv.two = drv_on & (modulation_out_ff ^ flip_two);
      nxt_drv.one_oe = drv_on;
      nxt_drv.two_oe = drv_on;
      // unsupported style codes are stored as written; software keeps clear of them
      nxt_drv.style = drv_mode_ff[DRV_STYLE_LSB +: 3];
   end

   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         mod_base_ff <= 1'b0;
         pulse_cnt_ff <= 4'h0;
         modulation_out_ff <= 1'b0;
         drv_ff <= '0;
      end else begin
         mod_base_ff <= nxt_mod_base;
         pulse_cnt_ff <= nxt_pulse_cnt;
         modulation_out_ff <= nxt_mod_out;
         drv_ff <= nxt_drv;
      end
   end

   // ---------------- transmit crc ----------------
   logic [15:0] crc_start;

   rtc_preset_rom u_rom (
      .sys_clk(sys_clk),
      .rstn(rstn),
      .kind(crc_kind),
      .sel(crc_start_sel),
      .user_value(user_crc_start),
      .start_ff(crc_start)
   );

   function automatic logic [15:0] crc_step(input logic [15:0] crc, input logic [1:0] kind, input logic b);
      logic [15:0] poly;
      logic [15:0] mask;
      logic fb;
      poly = POLY_CRC16;
      mask = 16'hffff;
      fb = crc[15] ^ b;
      case (kind)
         KIND_CRC5: begin
            poly = POLY_CRC5;
            mask = 16'h001f;
            fb = crc[4] ^ b;
         end
         KIND_CRC8: begin
            poly = POLY_CRC8;
            mask = 16'h00ff;
            fb = crc[7] ^ b;
         end
         default: ;
      endcase
      crc_step = ({crc[14:0], 1'b0} ^ (fb ? poly : 16'h0000)) & mask;
   endfunction : crc_step

   rtc_crc_state_t state_ff, nxt_state;
   logic [15:0] crc_ff, nxt_crc;
   logic [4:0] send_cnt_ff, nxt_send_cnt;
   logic [4:0] crc_width;
   logic nxt_crc_bit, nxt_crc_bit_valid, append_ok;
   logic [15:0] crc_upd;

   always_comb begin
      case (crc_kind)
         KIND_CRC5: crc_width = WIDTH_CRC5;
         KIND_CRC8: crc_width = WIDTH_CRC8;
         default: crc_width = WIDTH_CRC16;
      endcase
      append_ok = crc_setup_ff[CRC_APPEND_BIT] && crc_kind != 2'h3;
      // the last data bit rides with frame_end, so it is folded in before the crc closes
      crc_upd = data_bit_valid ? crc_step(crc_ff, crc_kind, data_bit) : crc_ff;
      nxt_state = state_ff;
      nxt_crc = crc_ff;
      nxt_send_cnt = send_cnt_ff;
      nxt_crc_bit = 1'b0;
      nxt_crc_bit_valid = 1'b0;
      case (state_ff)
         CRC_IDLE: begin
            if (frame_start) begin
               nxt_crc = crc_start;
               nxt_state = CRC_RUN;
            end
         end
         CRC_RUN: begin
            nxt_crc = crc_upd;
            if (frame_end) begin
               if (append_ok) begin
                  // left-align so the msb always leaves from bit 15
                  nxt_crc = (crc_setup_ff[CRC_COMPLEMENT_BIT] ? ~crc_upd : crc_upd) << (5'h10 - crc_width);
                  nxt_send_cnt = crc_width;
                  nxt_state = CRC_SEND;
               end else begin
                  nxt_state = CRC_IDLE;
               end
            end
         end
         CRC_SEND: begin
            nxt_crc_bit = crc_ff[15];
            nxt_crc_bit_valid = 1'b1;
            nxt_crc = {crc_ff[14:0], 1'b0};
            nxt_send_cnt = send_cnt_ff - 5'h01;
            if (send_cnt_ff == 5'h01) begin
               nxt_state = CRC_IDLE;
            end
         end
         default: nxt_state = CRC_IDLE;
      endcase
   end

   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         state_ff <= CRC_IDLE;
         crc_ff <= START_ZERO;
         send_cnt_ff <= 5'h00;
         crc_bit_ff <= 1'b0;
         crc_bit_valid_ff <= 1'b0;
      end else begin
         state_ff <= nxt_state;
         crc_ff <= nxt_crc;
         send_cnt_ff <= nxt_send_cnt;
         crc_bit_ff <= nxt_crc_bit;
         crc_bit_valid_ff <= nxt_crc_bit_valid;
      end
   end

   assign crc_busy = state_ff != CRC_IDLE;

   // ---------------- checks ----------------
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rstn);

   driver_enable_a: assert property (bus.wr && bus.addr == ADDR_DRV_MODE |=> ##1
      (drv_ff.one_oe == $past(bus.wdata[3], 2)) && (drv_ff.two_oe == $past(bus.wdata[3], 2)))
      else $error("driver enables do not follow the enable bit");
   driver_two_flip_a: assert property ($past(drv_on) && $past(flip_two) |-> drv_ff.two != $past(modulation_out_ff))
      else $error("second driver not inverted");
   driver_one_flip_a: assert property ($past(drv_on) && !$past(flip_one) |-> drv_ff.one == $past(modulation_out_ff))
      else $error("first driver polarity wrong");
   full_swing_a: assert property (full_swing |-> carrier_level_reduction == 2'h0)
      else $error("level reduction active under full swing");
   no_source_a: assert property (mod_source == SRC_NONE && $past(mod_source == SRC_NONE) && !mod_flip && !$past(mod_flip)
      |-> !mod_base_ff)
      else $error("modulation present with no source");
   mod_flip_a: assert property (mod_source == SRC_ENVELOPE && mod_flip |=> mod_base_ff == !$past(internal_envelope))
      else $error("modulation inversion wrong");
   pulse_hold_a: assert property (pulse_cnt_ff != 4'h0 && !carrier_tick && !(mod_base_ff && !nxt_mod_base)
      |=> $stable(pulse_cnt_ff))
      else $error("overshoot pulse counted without carrier tick");
   crc_send_a: assert property (state_ff == CRC_RUN && frame_end && append_ok |=> ##1 crc_bit_valid_ff [*5])
      else $error("crc not appended");
   reserved_read_a: assert property (bus.rd && bus.addr == ADDR_CRC_SETUP |=> rdata_ff[7] == 1'b0)
      else $error("reserved bit reads nonzero");
   crc_complement_a: assert property (state_ff == CRC_RUN && frame_end && append_ok && crc_kind == KIND_CRC16
      |=> crc_ff == (crc_setup_ff[CRC_COMPLEMENT_BIT] ? ~$past(crc_upd) : $past(crc_upd)))
      else $error("crc complement wrong");

   crc16_frame_c: cover property (state_ff == CRC_SEND && crc_kind == KIND_CRC16 ##1 state_ff == CRC_SEND);
   overshoot_c: cover property (pulse_cnt_ff != 4'h0 && carrier_tick);
   drivers_on_c: cover property (drv_ff.one_oe && drv_ff.one && !drv_ff.two);
endmodule : rtc_regs
`default_nettype wire

//--- inc/rtc_pkg.sv
`default_nettype none
package rtc_pkg;
   // register byte addresses
   localparam logic [7:0] ADDR_DRV_MODE = 8'h28;
   localparam logic [7:0] ADDR_AMPLITUDE = 8'h29;
   localparam logic [7:0] ADDR_MOD_CTRL = 8'h2a;
   localparam logic [7:0] ADDR_LOAD_TRIM = 8'h2b;
   localparam logic [7:0] ADDR_CRC_SETUP = 8'h2c;

   // reset values
   localparam logic [7:0] RST_DRV_MODE = 8'h00;
   localparam logic [7:0] RST_AMPLITUDE = 8'h00;
   localparam logic [7:0] RST_MOD_CTRL = 8'h00;
   localparam logic [7:0] RST_LOAD_TRIM = 8'h00;
   localparam logic [7:0] RST_CRC_SETUP = 8'h00;

   // writable bits; everything else is reserved and reads zero
   localparam logic [7:0] MASK_DRV_MODE = 8'hcf;
   localparam logic [7:0] MASK_AMPLITUDE = 8'hdf;
   localparam logic [7:0] MASK_MOD_CTRL = 8'hff;
   localparam logic [7:0] MASK_LOAD_TRIM = 8'hff;
   localparam logic [7:0] MASK_CRC_SETUP = 8'h7f;

   // field positions
   localparam int DRV_TWO_FLIP_BIT = 7;
   localparam int DRV_ONE_FLIP_BIT = 6;
   localparam int DRV_ON_BIT = 3;
   localparam int DRV_STYLE_LSB = 0;
   localparam int AMP_REDUCTION_LSB = 6;
   localparam int AMP_RESIDUAL_LSB = 0;
   localparam int MOD_PULSE_LSB = 4;
   localparam int MOD_FULL_SWING_BIT = 3;
   localparam int MOD_FLIP_BIT = 2;
   localparam int MOD_SOURCE_LSB = 0;
   localparam int LOAD_TIMER_ONE_LSB = 4;
   localparam int LOAD_TRIM_LSB = 0;
   localparam int CRC_START_LSB = 4;
   localparam int CRC_KIND_LSB = 2;
   localparam int CRC_COMPLEMENT_BIT = 1;
   localparam int CRC_APPEND_BIT = 0;

   // modulation source codes
   localparam logic [1:0] SRC_NONE = 2'h0;
   localparam logic [1:0] SRC_ENVELOPE = 2'h1;
   localparam logic [1:0] SRC_EXTERNAL = 2'h2;

   // crc kind codes, widths and polynomials
   localparam logic [1:0] KIND_CRC5 = 2'h0;
   localparam logic [1:0] KIND_CRC8 = 2'h1;
   localparam logic [1:0] KIND_CRC16 = 2'h2;
   localparam logic [4:0] WIDTH_CRC5 = 5'h05;
   localparam logic [4:0] WIDTH_CRC8 = 5'h08;
   localparam logic [4:0] WIDTH_CRC16 = 5'h10;
   localparam logic [15:0] POLY_CRC5 = 16'h0009;
   localparam logic [15:0] POLY_CRC8 = 16'h001d;
   localparam logic [15:0] POLY_CRC16 = 16'h1021;

   // crc start values
   localparam logic [2:0] START_USER = 3'h6;
   localparam logic [15:0] START16_1 = 16'h6363;
   localparam logic [15:0] START16_2 = 16'ha671;
   localparam logic [15:0] START16_3 = 16'hfffe;
   localparam logic [15:0] START16_7 = 16'hffff;
   localparam logic [15:0] START8_1 = 16'h0012;
   localparam logic [15:0] START8_2 = 16'h00bf;
   localparam logic [15:0] START8_3 = 16'h00fd;
   localparam logic [15:0] START8_7 = 16'h00ff;
   localparam logic [15:0] START5_1 = 16'h0012;
   localparam logic [15:0] START5_7 = 16'h001f;
   localparam logic [15:0] START_ZERO = 16'h0000;

   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } rtc_bus_t;

   typedef struct packed {
      logic one;
      logic one_oe;
      logic two;
      logic two_oe;
      logic [2:0] style;
   } rtc_drv_t;

   typedef enum logic [1:0] {CRC_IDLE, CRC_RUN, CRC_SEND} rtc_crc_state_t;
endpackage : rtc_pkg
`default_nettype wire

//--- sim/tb_rtc_regs.sv
`timescale 1ns/10ps
`default_nettype none
`define chk(got, exp) begin compares++; if ((got) !== (exp)) begin error_cnt++; \
   $display("[FAIL] %0t got %h exp %h", $time, (got), (exp)); end end
module tb_rtc_regs;
   import rtc_pkg::*;
   logic sys_clk, rstn, internal_envelope, external_modulation_input, carrier_tick;
   logic frame_start, data_bit_valid, data_bit, frame_end;
   logic [15:0] user_crc_start;
   rtc_bus_t bus;
   rtc_drv_t drv;
   logic [7:0] rdata;
   logic [7:0] rd_val;
   logic modulation_out, full_swing, crc_bit, crc_bit_valid, crc_busy;
   logic [1:0] reduction;
   logic [4:0] residual;
   logic [3:0] timer_one, load_trim;
   int error_cnt = 0;
   int compares = 0;

   rtc_regs dut (.sys_clk(sys_clk), .rstn(rstn), .bus(bus), .rdata_ff(rdata),
      .internal_envelope(internal_envelope), .external_modulation_input(external_modulation_input),
      .carrier_tick(carrier_tick), .drv_ff(drv), .modulation_out_ff(modulation_out),
      .carrier_level_reduction(reduction), .full_swing(full_swing), .residual_carrier(residual),
      .overshoot_timer_one_value(timer_one), .expected_load_current_trim(load_trim),
      .user_crc_start(user_crc_start), .frame_start(frame_start), .data_bit_valid(data_bit_valid),
      .data_bit(data_bit), .frame_end(frame_end), .crc_bit_ff(crc_bit),
      .crc_bit_valid_ff(crc_bit_valid), .crc_busy(crc_busy));

   initial begin
      sys_clk = 1'b0;
      forever #2 sys_clk = ~sys_clk;
   end

   task automatic give_verdict();
      $display("errors %0d compares %0d", error_cnt, compares);
      if (error_cnt == 0 && compares > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : give_verdict

   task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
      @(posedge sys_clk);
      bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge sys_clk);
      bus.wr <= 1'b0;
   endtask : wr_reg

   // read data stands only in the cycle after the read edge
   task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
      @(posedge sys_clk);
      bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
      @(posedge sys_clk);
      bus.rd <= 1'b0;
      #1;
      d = rdata;
   endtask : rd_reg

   task automatic idle(input int n);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask : idle

   // reference crc: msb-first shift, no reflection
   function automatic logic [15:0] crc_ref(input logic [15:0] start, input logic [15:0] poly,
                                           input int w, input logic [7:0] d, input logic inv);
      logic [15:0] crc;
      logic [15:0] mask;
      logic fb;
      mask = 16'hffff >> (16 - w);
      crc = start & mask;
      for (int i = 7; i >= 0; i--) begin
         fb = crc[w-1] ^ d[i];
         crc = (crc << 1) & mask;
         if (fb) crc = crc ^ poly;
      end
      return inv ? (crc ^ mask) : crc;
   endfunction : crc_ref

   task automatic frame(input logic [7:0] cfg, input logic [7:0] d, input int w, input logic [15:0] exp);
      logic [15:0] got;
      int n;
      got = 16'h0000;
      n = 0;
      wr_reg(ADDR_CRC_SETUP, cfg);
      idle(2);
      @(posedge sys_clk);
      frame_start <= 1'b1;
      for (int i = 7; i >= 0; i--) begin
         @(posedge sys_clk);
         frame_start <= 1'b0;
         data_bit_valid <= 1'b1;
         data_bit <= d[i];
         frame_end <= (i == 0);
      end
      @(posedge sys_clk);
      data_bit_valid <= 1'b0;
      frame_end <= 1'b0;
      repeat (30) begin
         #1;
         if (crc_bit_valid === 1'b1) begin
            got = {got[14:0], crc_bit};
            n++;
         end
         @(posedge sys_clk);
      end
      #1;
      `chk(n, w)
      `chk(got, exp)
      `chk(crc_busy, 1'b0)
   endtask : frame

   logic [7:0] addrs [5] = '{ADDR_DRV_MODE, ADDR_AMPLITUDE, ADDR_MOD_CTRL, ADDR_LOAD_TRIM, ADDR_CRC_SETUP};
   logic [7:0] masks [5] = '{MASK_DRV_MODE, MASK_AMPLITUDE, MASK_MOD_CTRL, MASK_LOAD_TRIM, MASK_CRC_SETUP};
   // mod control, envelope, external, expected modulation
   logic [10:0] mod_tab [11] = '{11'h006, 11'h00d, 11'h00a, 11'h02c, 11'h02b, 11'h014,
                                 11'h013, 11'h032, 11'h075, 11'h01e, 11'h021};

   initial begin
      rstn = 1'b0;
      bus = '0;
      {internal_envelope, external_modulation_input, carrier_tick} = 3'b000;
      {frame_start, data_bit_valid, data_bit, frame_end} = 4'b0000;
      user_crc_start = 16'h0015;
      repeat (8) @(posedge sys_clk);
      rstn <= 1'b1;
      foreach (addrs[i]) begin
         rd_reg(addrs[i], rd_val);
         `chk(rd_val, 8'h00)
      end
      // reserved bits never store, unmapped place holds nothing
      foreach (addrs[i]) begin
         wr_reg(addrs[i], 8'hff);
         rd_reg(addrs[i], rd_val);
         `chk(rd_val, masks[i])
         wr_reg(addrs[i], 8'h00);
      end
      wr_reg(8'h2d, 8'hff);
      rd_reg(8'h2d, rd_val);
      `chk(rd_val, 8'h00)
      wr_reg(ADDR_CRC_SETUP, 8'hda);
      rd_reg(ADDR_CRC_SETUP, rd_val);
      `chk(rd_val, 8'h5a)
      idle(1);
      `chk(rdata, 8'h00)
      // drivers, modulation source idle
      wr_reg(ADDR_DRV_MODE, 8'h08);
      idle(4);
      `chk({drv.one_oe, drv.two_oe, drv.style}, 5'h18)
      `chk({drv.one, drv.two}, 2'b00)
      wr_reg(ADDR_DRV_MODE, 8'h4d);
      idle(4);
      `chk({drv.one_oe, drv.two_oe, drv.style}, 5'h1d)
      `chk({drv.one, drv.two}, 2'b10)
      // style codes 3 and 6 are off limits for software
      wr_reg(ADDR_DRV_MODE, 8'h8a);
      idle(4);
      `chk({drv.one, drv.two}, 2'b01)
      `chk(drv.style, 3'h2)
      wr_reg(ADDR_DRV_MODE, 8'hcc);
      idle(4);
      `chk({drv.one, drv.two}, 2'b11)
      wr_reg(ADDR_DRV_MODE, 8'h07);
      idle(4);
      `chk({drv.one_oe, drv.two_oe, drv.style}, 5'h07)
      // amplitude, full swing and trims
      for (int r = 0; r < 4; r++) begin
         wr_reg(ADDR_AMPLITUDE, {r[1:0], 6'h35});
         idle(2);
         `chk(reduction, r[1:0])
         `chk(residual, 5'h15)
      end
      wr_reg(ADDR_MOD_CTRL, 8'h08);
      idle(2);
      `chk({full_swing, reduction}, 3'h4)
      wr_reg(ADDR_LOAD_TRIM, 8'ha6);
      idle(2);
      `chk({timer_one, load_trim}, 8'ha6)
      // source and polarity table, no overshoot pulse
      foreach (mod_tab[i]) begin
         wr_reg(ADDR_MOD_CTRL, mod_tab[i][10:3]);
         internal_envelope <= mod_tab[i][2];
         external_modulation_input <= mod_tab[i][1];
         idle(5);
         `chk(modulation_out, mod_tab[i][0])
      end
      // overshoot pulse of three carrier clocks after modulation ends
      wr_reg(ADDR_MOD_CTRL, 8'h31);
      internal_envelope <= 1'b1;
      repeat (5) @(posedge sys_clk);
      internal_envelope <= 1'b0;
      idle(6);
      `chk(modulation_out, 1'b1)
      for (int t = 0; t < 3; t++) begin
         @(posedge sys_clk);
         carrier_tick <= 1'b1;
         @(posedge sys_clk);
         carrier_tick <= 1'b0;
         idle(5);
         `chk(modulation_out, t < 2)
      end
      wr_reg(ADDR_MOD_CTRL, 8'h00);
      // crc frames across kinds, start values and complement
      frame(8'h79, 8'ha5, 16, crc_ref(START16_7, POLY_CRC16, 16, 8'ha5, 1'b0));
      frame(8'h1b, 8'h3c, 16, crc_ref(START16_1, POLY_CRC16, 16, 8'h3c, 1'b1));
      frame(8'h25, 8'hc3, 8, crc_ref(START8_2, POLY_CRC8, 8, 8'hc3, 1'b0));
      frame(8'h35, 8'h96, 8, crc_ref(START8_3, POLY_CRC8, 8, 8'h96, 1'b0));
      frame(8'h63, 8'h81, 5, crc_ref(16'h0015, POLY_CRC5, 5, 8'h81, 1'b1));
      frame(8'h01, 8'h5a, 5, crc_ref(START_ZERO, POLY_CRC5, 5, 8'h5a, 1'b0));
      frame(8'h0d, 8'h5a, 0, 16'h0000);
      frame(8'h78, 8'h5a, 0, 16'h0000);
      give_verdict();
   end

   initial begin
      #(20000 * 4);
      error_cnt++;
      give_verdict();
   end
endmodule : tb_rtc_regs
`undef chk
`default_nettype wire
